// ### inc/mgmt_pkg.sv
package mgmt_pkg;
  // save area layout: slot indices in fill-down order
  localparam int NSLOT = 22;
  localparam int NARCH = 18;
  localparam logic [4:0] S_CTL0  = 5'h00;
  localparam logic [4:0] S_FLAGS = 5'h02;
  localparam logic [4:0] S_IP    = 5'h03;
  localparam logic [4:0] S_DBGC  = 5'h0D;
  localparam logic [4:0] S_DS    = 5'h0E;
  localparam logic [4:0] S_SS    = 5'h0F;
  localparam logic [4:0] S_CS    = 5'h10;
  localparam logic [4:0] S_ES    = 5'h11;
  localparam logic [4:0] S_TRAP  = 5'h12;
  localparam logic [4:0] S_RST   = 5'h13;
  localparam logic [4:0] S_REV   = 5'h14;
  localparam logic [4:0] S_BASE  = 5'h15;
  localparam logic [4:0] S_LAST  = 5'h15;
  // entry values and masks
  localparam logic [31:0] DEF_BASE    = 32'h0003_0000;
  localparam logic [31:0] ENTRY_IP    = 32'h0000_8000;
  localparam logic [31:0] ENTRY_FLAGS = 32'h0000_0002;
  localparam logic [31:0] ENTRY_DBG   = 32'h0000_0400;
  localparam logic [31:0] SEG_ZERO    = 32'h0000_0000;
  localparam logic [31:0] CTL0_CLR    = 32'h8000_000D;
  localparam logic [31:0] ALIGN_MASK  = 32'h0000_7FFF;
  // relocation and trap-restart bits set; revision level value is arbitrary
  localparam logic [31:0] REV_ID      = 32'h0003_005A;
  localparam logic [15:0] TRAP_CLEAR  = 16'h0000;
  localparam logic [15:0] TRAP_REDO   = 16'h00FF;
  localparam int          HALT_BIT    = 16;
  localparam int          TVALID_BIT  = 1;
  // apb register byte offsets
  localparam logic [7:0] A_STAT = 8'h00;
  localparam logic [7:0] A_BASE = 8'h04;
  localparam logic [7:0] A_CTRL = 8'h08;
  localparam logic       CTRL_RST = 1'b1;
  // offset of each slot above the base
  function automatic logic [15:0] slotOfs(input logic [4:0] s);
    case (s)
      5'h00: return 16'hFFFC;
      5'h01: return 16'hFFF8;
      5'h02: return 16'hFFF4;
      5'h03: return 16'hFFF0;
      5'h0C: return 16'hFFCC;
      5'h0D: return 16'hFFC8;
      5'h0E: return 16'hFFB4;
      5'h0F: return 16'hFFB0;
      5'h10: return 16'hFFAC;
      5'h11: return 16'hFFA8;
      5'h12: return 16'hFFA4;
      5'h13: return 16'hFF00;
      5'h14: return 16'hFEFC;
      5'h15: return 16'hFEF8;
      default: return 16'hFFEC - {9'h000, s - 5'h04, 2'b00};
    endcase
  endfunction : slotOfs
  // save area memory request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } memReq_s;
  // execution environment while in management mode
  typedef struct packed {
    logic realMode;
    logic limit4g;
    logic default16;
    logic ipTrunc16;
    logic farBase20;
    logic realVectors;
    logic nmiBlock;
    logic initBlock;
  } modeCtl_s;
  typedef enum {ST_IDLE, ST_ACK, ST_SAVE, ST_LOAD, ST_HANDLER,
                ST_RESTORE, ST_RESUME, ST_SHUTDOWN} state_e;
endpackage : mgmt_pkg

// ### sim/mgmt_chipset_model.sv
`timescale 1ns/1ps
// chipset side: isolated management memory answering the save/restore requests
module mgmt_chipset_model
  import mgmt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       mgmtActiveOut_n,
  input  wire memReq_s    mem,
  input  wire logic [1:0] waitCycles,
  output logic            memAck,
  output logic [31:0]     memRdata
);
  logic [31:0] ram [logic [31:0]];  // sparse backing store
  logic [1:0]  cnt_q;               // wait states spent on current word
  logic        tog_q;               // flips each cycle for idle data
  int          nWr;                 // words written so far
  wire         sel = mem.req & ~mgmtActiveOut_n;

  // ack after the chosen number of wait states, one cycle wide
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      memAck <= 1'b0;
      cnt_q  <= 2'h0;
      tog_q  <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (memAck) begin
        memAck <= 1'b0;
        cnt_q  <= 2'h0;
      end else if (sel && cnt_q >= waitCycles) begin
        memAck <= 1'b1;
      end else if (sel) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (memAck && sel && mem.we) begin
      ram[mem.addr] = mem.wdata;
      nWr++;
    end
  end

  // read data only with ack, a changing pattern otherwise
  always_comb begin
    if (memAck && ram.exists(mem.addr))
      memRdata = ram[mem.addr];
    else
      memRdata = 32'hA5A5_5A5A ^ {32{tog_q}};
  end
endmodule : mgmt_chipset_model

// ### sim/mgmt_mode_entry_exit_bench.sv
`timescale 1ns/1ps
// bench: register access, entry/exit rounds with relocation, refusal, shutdown
module mgmt_mode_entry_exit_bench;
  import mgmt_pkg::*;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, intN, actN, a20N, a20Eff;
  logic bnd, halt, resume, archLoad, hcOut, ioOut, shut, mMode, memAck;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, trapDw, memRdata, rd, cur, nb, r;
  logic [NARCH-1:0][31:0] archIn, archOut, got, exp;
  logic [1:0]             wc;
  logic                   err, hc, io;
  modeCtl_s               modeCtl;
  memReq_s                mem;
  int                     bad_count, n_checks, w0;

  mgmt_mode_entry_exit u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mgmtInterruptIn_n(intN), .mgmtActiveOut_n(actN),
    .addrBit20MaskIn_n(a20N), .a20MaskEff_n(a20Eff), .instrBoundary(bnd),
    .haltState(halt), .resumeInstr(resume), .archIn(archIn), .trapDword(trapDw),
    .archOut(archOut), .archLoad(archLoad), .haltCycle(hcOut), .ioRestart(ioOut),
    .shutdown(shut), .managementMode(mMode), .modeCtl(modeCtl), .mem(mem),
    .memAck(memAck), .memRdata(memRdata));
  mgmt_chipset_model u_mem (.core_clk(core_clk), .nrst(nrst), .mgmtActiveOut_n(actN),
    .mem(mem), .waitCycles(wc), .memAck(memAck), .memRdata(memRdata));

  // clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // boundary opens at random cycles
  always @(posedge core_clk) bnd <= ($urandom % 4) != 0;

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // save-slot offset above the base
  function automatic logic [15:0] ofs(input int i);
    if (i < 12) return 16'hFFFC - 16'(4 * i);
    case (i)
      12: return 16'hFFCC; 13: return 16'hFFC8; 14: return 16'hFFB4; 15: return 16'hFFB0;
      16: return 16'hFFAC; 17: return 16'hFFA8; 18: return 16'hFFA4; 19: return 16'hFF00;
      20: return 16'hFEFC; default: return 16'hFEF8;
    endcase
  endfunction : ofs

  // wait for the load pulse, watching active during every access
  task automatic waitLoad();
    int k;
    k = 0;
    do begin
      @(posedge core_clk); k++;
      if (mem.req === 1'b1) check({31'h0, actN}, 32'h0);
    end while (archLoad !== 1'b1 && k < 2000);
    got = archOut; hc = hcOut; io = ioOut;
  endtask : waitLoad

  // one entry at base b, handler edits, then resume (misaligned base if bad)
  task automatic round(input logic [31:0] b, input logic [31:0] nbase, input logic bad);
    logic [31:0] sv;
    logic [15:0] rs;
    logic        hb;
    int          k;
    for (int i = 0; i < NARCH; i++) archIn[i] <= $urandom;
    trapDw <= $urandom; halt <= 1'($urandom); wc <= 2'($urandom);
    w0 = u_mem.nWr;
    @(posedge core_clk) intN <= 1'b0;
    k = 0;
    do begin @(posedge core_clk); k++; end while (actN !== 1'b0 && k < 200);
    check({31'h0, actN}, 32'h0);
    intN <= 1'b1;
    waitLoad();
    for (int i = 0; i < NARCH; i++) begin
      exp[i] = (i == 0) ? archIn[0] & ~CTL0_CLR : (i == 2) ? ENTRY_FLAGS :
               (i == 3) ? ENTRY_IP : (i == 13) ? ENTRY_DBG : (i == 16) ? b :
               (i == 14 || i == 15 || i == 17) ? SEG_ZERO : archIn[i];
      check(got[i], exp[i]);
    end
    for (int i = 0; i < NSLOT; i++) begin
      // the code segment slot keeps the interrupted program's value
      sv = (i == 21) ? b : (i == 18) ? trapDw : (i == 20) ? REV_ID :
           (i == 19) ? {15'h0000, halt, TRAP_CLEAR} : archIn[i];
      check(u_mem.ram[b + {16'h0000, ofs(i)}], sv);
      if (i < NARCH) exp[i] = sv;
    end
    check(32'(u_mem.nWr - w0), 32'd22);
    check({22'h0, a20Eff, mMode, modeCtl}, 32'h0000_03FF);
    apb(1'b0, A_BASE, 32'h0);
    check(rd, b);
    apb(1'b0, A_STAT, 32'h0);
    check(rd, 32'h1);
    // handler edits the image
    exp[11] = $urandom; hb = 1'($urandom); rs = $urandom % 2 ? TRAP_REDO : TRAP_CLEAR;
    u_mem.ram[b + 32'h0000_FFD0] = exp[11];
    u_mem.ram[b + 32'h0000_FF00] = {15'h0000, hb, rs};
    u_mem.ram[b + 32'h0000_FEF8] = bad ? nbase | 32'h0000_4000 : nbase;
    @(posedge core_clk) resume <= 1'b1;
    @(posedge core_clk) resume <= 1'b0;
    if (bad) begin
      k = 0;
      do begin @(posedge core_clk); k++; end while (shut !== 1'b1 && k < 300);
      // acknowledge is released one cycle after shutdown begins
      @(posedge core_clk);
      check({30'h0, shut, actN}, 32'h3);
      apb(1'b0, A_STAT, 32'h0);
      check(rd, 32'h2);
    end else begin
      waitLoad();
      for (int i = 0; i < NARCH; i++) check(got[i], exp[i]);
      check({30'h0, hc, io}, {30'h0, hb, rs == TRAP_REDO && trapDw[TVALID_BIT]});
      repeat (3) @(posedge core_clk);
      check({21'h0, a20Eff, mMode, modeCtl, actN}, 32'h1);
    end
  endtask : round

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // watchdog
  initial begin
    #200000;
    bad_count++;
    $display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
    conclude();
  end

  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; intN = 1'b1; a20N = 1'b0; bnd = 1'b1; halt = 1'b0; resume = 1'b0;
    archIn = '0; trapDw = 32'h0; wc = 2'h0; bad_count = 0; n_checks = 0;
    void'($urandom(52128));
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    // reset values, read-only write, unmapped place
    apb(1'b0, A_BASE, 32'h0);
    check(rd, DEF_BASE);
    apb(1'b0, A_CTRL, 32'h0);
    check(rd, {31'h0, CTRL_RST});
    apb(1'b1, A_STAT, 32'hFFFF_FFFF);
    apb(1'b0, A_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test registers done");
    // recognition disabled: pin held low is ignored
    apb(1'b1, A_CTRL, 32'h0);
    @(posedge core_clk) intN <= 1'b0;
    repeat (20) @(posedge core_clk);
    check({31'h0, actN}, 32'h1);
    // release the pin so re-enabling does not start an entry
    intN <= 1'b1;
    apb(1'b1, A_CTRL, {31'h0, CTRL_RST});
    $display("test refusal done");
    // rounds with relocation from the second entry on
    cur = DEF_BASE;
    for (int it = 0; it < 4; it++) begin
      r = $urandom;
      nb = (it == 0) ? cur : r & 32'hFFFF_8000;
      round(cur, nb, 1'b0);
      cur = nb;
      $display("test round %0d done", it);
    end
    round(cur, cur, 1'b1);
    $display("test shutdown done");
    conclude();
  end
endmodule : mgmt_mode_entry_exit_bench

// ### verilog/mgmt_mode_entry_exit.sv
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
// What this block does
// - acknowledge interrupt, save state, enter handler
// - resume restores state, drops acknowledge, continues
// - save fills down from top of region
// - entry loads pointer 8000h, code base the current management base
// - entry flags 2h, interrupts and stepping off
// - entry clears four control register zero bits
// - entry debug control loads 400h
// - entry zeroes data, extra, stack segments
// - nmi, init blocked, address bit 20 mask released
// - real addressing, 4G limits, 16-bit defaults
// - pointer truncation, far base within 20 bits
// - interrupts use real-mode vector table
// - fixed save offsets for main registers
// - trap, restart, revision, base slots placed
// - handler edits restored on resume
// - base default, relocation, misalignment shutdown
// - halt slot records and selects halt return
// - trap restart slot cleared, 00FFh re-executes when the trap valid bit is set
module mgmt_mode_entry_exit
  import mgmt_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   mgmtInterruptIn_n,
  output logic                        mgmtActiveOut_n,
  input  wire logic                   addrBit20MaskIn_n,
  output logic                        a20MaskEff_n,
  input  wire logic                   instrBoundary,
  input  wire logic                   haltState,
  input  wire logic                   resumeInstr,
  input  wire logic [NARCH-1:0][31:0] archIn,
  input  wire logic [31:0]            trapDword,
  output logic      [NARCH-1:0][31:0] archOut,
  output logic                        archLoad,
  output logic                        haltCycle,
  output logic                        ioRestart,
  output logic                        shutdown,
  output logic                        managementMode,
  output modeCtl_s                    modeCtl,
  output memReq_s                     mem,
  input  wire logic                   memAck,
  input  wire logic [31:0]            memRdata
);

  // pin synchronisers
  logic smiS1_q, smiS2_q;             // interrupt pin stages
  logic a20S1_q, a20S2_q;             // mask pin stages
  // control state
  state_e           st_q;             // sequencer state
  logic [4:0]       slot_q;           // save slot counter
  logic [31:0]      img_q [NSLOT];    // save area image
  logic [31:0]      base_q;           // management base
  logic             active_q;         // acknowledge level
  logic             enable_q;         // software recognise enable
  logic [NARCH-1:0][31:0] archOut_q;  // register values to core
  logic             load_q;           // core load pulse
  logic             halt_q;           // halt cycle pulse
  logic             redo_q;           // port restart pulse
  logic [31:0]      prdata_q;         // apb read data
  // decode wires
  logic        smiSeen;               // entry request accepted
  logic        lastSlot;              // final slot of a pass
  logic        misaligned;            // restored base off 32K
  logic        apbWr;                 // apb write access
  logic        apbHit;                // mapped apb address
  logic [31:0] apbRd;                 // apb read mux

  // snapshot word for a slot at entry
  function automatic logic [31:0] capWord(input logic [4:0] s);
    case (s)
      S_TRAP:  return trapDword;
      S_RST:   return {15'h0000, haltState, TRAP_CLEAR};
      S_REV:   return REV_ID;
      S_BASE:  return base_q;
      default: return archIn[s];
    endcase
  endfunction : capWord

  // value loaded into the core at entry
  function automatic logic [31:0] entryWord(input logic [4:0] s);
    case (s)
      S_CTL0:  return img_q[s] & ~CTL0_CLR;
      S_FLAGS: return ENTRY_FLAGS;
      S_IP:    return ENTRY_IP;
      S_DBGC:  return ENTRY_DBG;
      S_DS, S_SS, S_ES: return SEG_ZERO;
      S_CS:    return base_q;
      default: return img_q[s];
    endcase
  endfunction : entryWord
  // two stages on both pins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      smiS1_q <= 1'b1;
      smiS2_q <= 1'b1;
      a20S1_q <= 1'b1;
      a20S2_q <= 1'b1;
    end else begin
      smiS1_q <= mgmtInterruptIn_n;
      smiS2_q <= smiS1_q;
      a20S1_q <= addrBit20MaskIn_n;
      a20S2_q <= a20S1_q;
    end
  end

  // recognise only at an instruction boundary
  assign smiSeen    = !smiS2_q && enable_q && instrBoundary && st_q == ST_IDLE;
  assign lastSlot   = slot_q == S_LAST;
  assign misaligned = |(img_q[S_BASE] & ALIGN_MASK);
  // sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= ST_IDLE;
      slot_q   <= '0;
      active_q <= 1'b0;
      load_q   <= 1'b0;
      halt_q   <= 1'b0;
      redo_q   <= 1'b0;
      base_q   <= DEF_BASE;
    end else begin
      load_q <= 1'b0;
      halt_q <= 1'b0;
      redo_q <= 1'b0;
      case (st_q)
        // wait for the interrupt
        ST_IDLE: begin
          if (smiSeen) begin
            active_q <= 1'b1;
            st_q     <= ST_ACK;
          end
        end
        // one cycle of acknowledge before memory traffic
        ST_ACK: begin
          slot_q <= '0;
          st_q   <= ST_SAVE;
        end
        ST_SAVE: begin
          if (memAck) begin
            slot_q <= lastSlot ? '0 : slot_q + 5'h01;
            st_q   <= lastSlot ? ST_LOAD : ST_SAVE;
          end
        end
        ST_LOAD: begin
          load_q <= 1'b1;
          st_q   <= ST_HANDLER;
        end
        // handler runs until resume
        ST_HANDLER: begin
          if (resumeInstr) begin
            slot_q <= '0;
            st_q   <= ST_RESTORE;
          end
        end
        ST_RESTORE: begin
          if (memAck) begin
            slot_q <= lastSlot ? '0 : slot_q + 5'h01;
            st_q   <= lastSlot ? ST_RESUME : ST_RESTORE;
          end
        end
        ST_RESUME: begin
          if (misaligned) begin
            st_q <= ST_SHUTDOWN;
          end else begin
            base_q   <= img_q[S_BASE];
            load_q   <= 1'b1;
            halt_q   <= img_q[S_RST][HALT_BIT];
            redo_q   <= img_q[S_RST][15:0] == TRAP_REDO
                        && img_q[S_TRAP][TVALID_BIT];
            active_q <= 1'b0;
            st_q     <= ST_IDLE;
          end
        end
        // stays here until hardware reset
        ST_SHUTDOWN: begin
          active_q <= 1'b0;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // save image: snapshot at entry, refill on restore
  always_ff @(posedge core_clk) begin
    if (smiSeen) begin
      for (int i = 0; i < NSLOT; i++) begin
        img_q[i] <= capWord(5'(i));
      end
    end else if (st_q == ST_RESTORE && memAck) begin
      img_q[slot_q] <= memRdata;
    end
  end

  // registers handed to the core
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      archOut_q <= '0;
    end else if (st_q == ST_LOAD) begin
      for (int i = 0; i < NARCH; i++) begin
        archOut_q[i] <= entryWord(5'(i));
      end
    end else if (st_q == ST_RESUME && !misaligned) begin
      for (int i = 0; i < NARCH; i++) begin
        archOut_q[i] <= img_q[i];
      end
    end
  end

  // tail slots end at base slot
  assign mem.req   = st_q == ST_SAVE || st_q == ST_RESTORE;
  assign mem.we    = st_q == ST_SAVE;
  assign mem.addr  = base_q + {16'h0000, slotOfs(slot_q)};
  assign mem.wdata = img_q[slot_q];
  assign mgmtActiveOut_n = !active_q;
  assign managementMode  = active_q;
  assign archOut         = archOut_q;
  assign archLoad        = load_q;
  assign haltCycle       = halt_q;
  assign ioRestart       = redo_q;
  assign shutdown        = st_q == ST_SHUTDOWN;
  assign a20MaskEff_n = active_q ? 1'b1 : a20S2_q;
  assign modeCtl.nmiBlock    = active_q;
  assign modeCtl.initBlock   = active_q;
  assign modeCtl.realMode    = active_q;
  assign modeCtl.limit4g     = active_q;
  assign modeCtl.default16   = active_q;
  assign modeCtl.ipTrunc16   = active_q;
  assign modeCtl.farBase20   = active_q;
  assign modeCtl.realVectors = active_q;
  // apb slave: zero wait, read data latched in setup
  assign apbWr   = psel && penable && pwrite;
  assign apbHit  = paddr == A_STAT || paddr == A_BASE || paddr == A_CTRL;
  assign apbRd   = paddr == A_STAT ? {30'h0, shutdown, active_q}
                 : paddr == A_BASE ? base_q
                 : paddr == A_CTRL ? {31'h0, enable_q} : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apbHit;
  assign prdata  = prdata_q;
  // apb registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enable_q <= CTRL_RST;
      prdata_q <= '0;
    end else begin
      if (psel && !penable) begin
        prdata_q <= apbRd;
      end
      if (apbWr && paddr == A_CTRL) begin
        enable_q <= pwdata[0];
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_ack;
    smiSeen |=> st_q == ST_ACK && !mgmtActiveOut_n ##1 st_q == ST_SAVE;
  endproperty
  a_ack: assert property (p_ack) else $error("entry not acknowledged");
  property p_held;
    st_q inside {ST_ACK, ST_SAVE, ST_LOAD, ST_HANDLER, ST_RESTORE} |-> !mgmtActiveOut_n;
  endproperty
  a_held: assert property (p_held) else $error("active dropped early");
  property p_down;
    st_q == ST_SAVE && memAck && !lastSlot |=> mem.addr < $past(mem.addr);
  endproperty
  a_down: assert property (p_down) else $error("save not filling down");
  property p_ip;
    $past(st_q) == ST_LOAD |-> archLoad && archOut[S_IP] == ENTRY_IP;
  endproperty
  a_ip: assert property (p_ip) else $error("entry pointer wrong");
  property p_flags;
    $past(st_q) == ST_LOAD |-> archOut[S_FLAGS] == ENTRY_FLAGS;
  endproperty
  a_flags: assert property (p_flags) else $error("entry flags wrong");
  property p_cr0;
    $past(st_q) == ST_LOAD |-> (archOut[S_CTL0] & CTL0_CLR) == SEG_ZERO;
  endproperty
  a_cr0: assert property (p_cr0) else $error("control bits not cleared");
  property p_dbg;
    $past(st_q) == ST_LOAD |-> archOut[S_DBGC] == ENTRY_DBG && archOut[S_DS] == SEG_ZERO;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug or segment wrong");
  property p_a20;
    managementMode |-> a20MaskEff_n && modeCtl.nmiBlock;
  endproperty
  a_a20: assert property (p_a20) else $error("mask not forced");
  property p_align;
    st_q == ST_RESUME && misaligned |=> shutdown [*3];
  endproperty
  a_align: assert property (p_align) else $error("misaligned base kept running");
  property p_exit;
    st_q == ST_RESUME && !misaligned |=> mgmtActiveOut_n && archLoad && st_q == ST_IDLE;
  endproperty
  a_exit: assert property (p_exit) else $error("resume incomplete");
  c_entry: cover property (st_q == ST_SAVE ##[1:100] st_q == ST_HANDLER);
  c_resume: cover property (st_q == ST_RESTORE ##[1:100] st_q == ST_IDLE);
  c_halt: cover property (haltCycle);
  c_shut: cover property (shutdown);
endmodule : mgmt_mode_entry_exit
